// ==== hdl/throttle_adc_pkg.sv ====
// constants for the throttle source and adc control register pair
// assumes a 25 MHz system clock; times are in ns, counts are derived
`default_nettype none

package throttle_adc_pkg;

    // ************************************************************
    // command codes and reset values
    // ************************************************************
    localparam logic [7:0] CMD_THROTTLE_CFG = 8'h34;
    localparam logic [7:0] CMD_ADC_CTRL = 8'h35;
    localparam logic [15:0] THROTTLE_CFG_RST = 16'h81a0;
    localparam logic [15:0] ADC_CTRL_RST = 16'h2000;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned TC_VTH_MSB = 15;
    localparam int unsigned TC_VTH_LSB = 10;
    localparam int unsigned TC_DEG_MSB = 9;
    localparam int unsigned TC_DEG_LSB = 8;
    localparam int unsigned TC_DROOP = 7;
    localparam int unsigned TC_COMP = 6;
    localparam int unsigned TC_CRIT = 5;
    localparam int unsigned TC_NOM = 4;
    localparam int unsigned TC_DCHG = 3;
    localparam int unsigned TC_VSYS = 2;
    localparam int unsigned TC_BATREM = 1;
    localparam int unsigned TC_ACREM = 0;
    localparam int unsigned AC_MODE = 15;
    localparam int unsigned AC_START = 14;
    localparam int unsigned AC_RANGE = 13;

    // ************************************************************
    // thresholds
    // ************************************************************
    localparam logic [15:0] DCHG_STEP_MA = 16'h0200;
    localparam logic [15:0] DCHG_ZERO_MA = 16'h0080;
    localparam logic [23:0] NOM_PCT = 24'h00_006e;
    localparam logic [23:0] NOM_BASE = 24'h00_0064;

    // ************************************************************
    // timing: time in ns, cycles rounded up except the adc slot and period, which truncate
    // ************************************************************
    localparam int unsigned CLK_NS = 40;
    localparam int unsigned DEG_100US_NS = 100_000;
    localparam int unsigned DEG_1P6MS_NS = 1_600_000;
    localparam int unsigned DEG_6MS_NS = 6_000_000;
    localparam int unsigned DEG_12MS_NS = 12_000_000;
    localparam int unsigned NOM_1MS_NS = 1_000_000;
    localparam int unsigned NOM_50MS_NS = 50_000_000;
    localparam int unsigned ADC_PASS_NS = 10_000_000;
    localparam int unsigned ADC_PERIOD_NS = 1_000_000_000;
    localparam int unsigned PULSE_NS = 10_000;
    localparam int unsigned ADC_CHANNELS = 8;
    localparam int unsigned DEG_100US_CYC = (DEG_100US_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned DEG_1P6MS_CYC = (DEG_1P6MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned DEG_6MS_CYC = (DEG_6MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned DEG_12MS_CYC = (DEG_12MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned NOM_1MS_CYC = (NOM_1MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned NOM_50MS_CYC = (NOM_50MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ADC_SLOT_CYC = ADC_PASS_NS / CLK_NS / ADC_CHANNELS;
    localparam int unsigned ADC_PERIOD_CYC = ADC_PERIOD_NS / CLK_NS;
    localparam int unsigned PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {ADC_IDLE, ADC_UPDATE_MODE, ADC_WAIT} adc_state_t;

endpackage

`default_nettype wire

// ==== hdl/throttle_adc_config.sv ====
// throttle source configuration and adc control registers with their logic
// assumes a command-level register port behind an external smbus engine,
// and monitored conditions already synchronous to sys_clk_i
`timescale 1ns/100ps
`default_nettype none

module throttle_adc_config #(
    parameter int unsigned DEG_1P6MS_CYC = throttle_adc_pkg::DEG_1P6MS_CYC,
    parameter int unsigned DEG_6MS_CYC = throttle_adc_pkg::DEG_6MS_CYC,
    parameter int unsigned DEG_12MS_CYC = throttle_adc_pkg::DEG_12MS_CYC,
    parameter int unsigned NOM_1MS_CYC = throttle_adc_pkg::NOM_1MS_CYC,
    parameter int unsigned NOM_50MS_CYC = throttle_adc_pkg::NOM_50MS_CYC,
    parameter int unsigned ADC_SLOT_CYC = throttle_adc_pkg::ADC_SLOT_CYC,
    parameter int unsigned ADC_PERIOD_CYC = throttle_adc_pkg::ADC_PERIOD_CYC
) (
    // clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // register port by command code
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_cmd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // monitored conditions
    input wire logic [15:0] battery_discharge_current_i,
    input wire logic [15:0] input_current_i,
    input wire logic [15:0] host_input_current_limit_i,
    input wire logic nominal_deglitch_long_i,
    input wire logic input_droop_i,
    input wire logic ext_comparator_i,
    input wire logic critical_input_overcurrent_i,
    input wire logic low_system_voltage_i,
    input wire logic battery_present_i,
    input wire logic adapter_present_i,
    input wire logic min_voltage_protect_mode_i,
    input wire logic low_power_mode_i,
    // throttle output
    output logic cpu_throttle_n_o,
    // adc sequencer
    output logic adc_busy_o,
    output logic [2:0] adc_ch_sel_o,
    output logic adc_update_o,
    output logic adc_range_select_o
);

    // ************************************************************
    // helpers
    // ************************************************************

    // lowest enabled channel at or above from: {found, index}
    function automatic logic [3:0] next_enabled(input logic [7:0] en, input logic [3:0] from);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (en[i] && (4'(i) >= from)) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    logic [15:0] tc_q;
    logic [15:0] ac_q;
    logic [15:0] rdata_q;
    logic rvalid_q;
    logic wr_tc;
    logic wr_ac;
    logic bat_prev_q;
    logic ac_prev_q;
    logic vsys_prev_q;
    logic vap_prev_q;
    logic vap_rise;
    logic evt;
    logic level;
    logic [15:0] pulse_q;
    logic throttle_n_q;
    logic [15:0] dchg_thr;
    logic [5:0] vth;
    logic [1:0] deg_raw;
    logic [1:0] deg_hit;
    logic [31:0] deg_lim [2];
    throttle_adc_pkg::adc_state_t st_q;
    logic [2:0] ch_q;
    logic [31:0] slot_q;
    logic [31:0] period_q;
    logic busy_q;
    logic upd_q;
    logic pass_go;
    logic pass_end;
    logic clear_start;
    logic [3:0] nxt_first;
    logic [3:0] nxt_after;

    // ************************************************************
    // register port
    // ************************************************************

    assign wr_tc = ce_i && reg_wr_i && (reg_cmd_i == throttle_adc_pkg::CMD_THROTTLE_CFG);
    assign wr_ac = ce_i && reg_wr_i && (reg_cmd_i == throttle_adc_pkg::CMD_ADC_CTRL);
    assign vap_rise = min_voltage_protect_mode_i && !vap_prev_q;

    // throttle config: the protect-mode set is applied last so it beats a host write
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tc_q <= throttle_adc_pkg::THROTTLE_CFG_RST;
        end else if (ce_i) begin
            if (wr_tc) begin
                tc_q <= reg_wdata_i;
            end
            if (vap_rise) begin
                tc_q[throttle_adc_pkg::TC_VSYS] <= 1'b1;
            end
        end
    end

    // adc control: a host write in the same cycle as completion wins
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ac_q <= throttle_adc_pkg::ADC_CTRL_RST;
        end else if (ce_i) begin
            if (clear_start) begin
                ac_q[throttle_adc_pkg::AC_START] <= 1'b0;
            end
            if (wr_ac) begin
                ac_q <= reg_wdata_i;
            end
        end
    end

    // read data one cycle after the strobe; unknown commands read zero
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else if (ce_i) begin
            rvalid_q <= reg_rd_i;
            if (reg_rd_i) begin
                if (reg_cmd_i == throttle_adc_pkg::CMD_THROTTLE_CFG) begin
                    rdata_q <= tc_q;
                end else if (reg_cmd_i == throttle_adc_pkg::CMD_ADC_CTRL) begin
                    rdata_q <= ac_q;
                end else begin
                    rdata_q <= 16'h0000;
                end
            end
        end
    end

    // ************************************************************
    // current trip filters
    // ************************************************************

    // code zero is not a zero threshold: it trips at the smallest level
    assign vth = tc_q[throttle_adc_pkg::TC_VTH_MSB:throttle_adc_pkg::TC_VTH_LSB];
    assign dchg_thr = (vth == 6'h00) ? throttle_adc_pkg::DCHG_ZERO_MA :
        16'(vth) * throttle_adc_pkg::DCHG_STEP_MA;
    assign deg_raw[0] = battery_discharge_current_i > dchg_thr;
    assign deg_raw[1] = (24'(input_current_i) * throttle_adc_pkg::NOM_BASE) >
        (24'(host_input_current_limit_i) * throttle_adc_pkg::NOM_PCT);

    // deglitch lengths for both filters
    always_comb begin
        case (tc_q[throttle_adc_pkg::TC_DEG_MSB:throttle_adc_pkg::TC_DEG_LSB])
            2'b00: deg_lim[0] = DEG_1P6MS_CYC;
            2'b01: deg_lim[0] = throttle_adc_pkg::DEG_100US_CYC;
            2'b10: deg_lim[0] = DEG_6MS_CYC;
            default: deg_lim[0] = DEG_12MS_CYC;
        endcase
        deg_lim[1] = nominal_deglitch_long_i ? NOM_50MS_CYC : NOM_1MS_CYC;
    end

    // condition must hold unbroken for the full count; any gap restarts it
    genvar g;
    for (g = 0; g < 2; g++) begin : g_deg
        logic [31:0] cnt_q;
        always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                cnt_q <= 32'h0000_0000;
            end else if (ce_i) begin
                if (!deg_raw[g]) begin
                    cnt_q <= 32'h0000_0000;
                end else if (cnt_q != deg_lim[g]) begin
                    cnt_q <= cnt_q + 32'h0000_0001;
                end
            end
        end
        assign deg_hit[g] = deg_raw[g] && (cnt_q == deg_lim[g]);
    end

    // ************************************************************
    // throttle output
    // ************************************************************

    // previous values for edge detection
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bat_prev_q <= 1'b0;
            ac_prev_q <= 1'b0;
            vsys_prev_q <= 1'b0;
            vap_prev_q <= 1'b0;
        end else if (ce_i) begin
            bat_prev_q <= battery_present_i;
            ac_prev_q <= adapter_present_i;
            vsys_prev_q <= low_system_voltage_i;
            vap_prev_q <= min_voltage_protect_mode_i;
        end
    end

    // one-shot sources and the level sources, each gated by its enable
    assign evt = (tc_q[throttle_adc_pkg::TC_BATREM] && bat_prev_q && !battery_present_i)
        || (tc_q[throttle_adc_pkg::TC_ACREM] && ac_prev_q && !adapter_present_i)
        || (tc_q[throttle_adc_pkg::TC_VSYS] && low_system_voltage_i && !vsys_prev_q);
    assign level = (tc_q[throttle_adc_pkg::TC_DROOP] && input_droop_i)
        || (tc_q[throttle_adc_pkg::TC_COMP] && ext_comparator_i)
        || (tc_q[throttle_adc_pkg::TC_CRIT] && critical_input_overcurrent_i)
        || (tc_q[throttle_adc_pkg::TC_NOM] && deg_hit[1])
        || (tc_q[throttle_adc_pkg::TC_DCHG] && deg_hit[0]);

    // pulse stretcher; a new event while stretching restarts the width
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pulse_q <= 16'h0000;
        end else if (ce_i) begin
            if (evt) begin
                pulse_q <= 16'(throttle_adc_pkg::PULSE_CYC - 1);
            end else if (pulse_q != 16'h0000) begin
                pulse_q <= pulse_q - 16'h0001;
            end
        end
    end

    // registered pin, low while anything enabled is active
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            throttle_n_q <= 1'b1;
        end else if (ce_i) begin
            throttle_n_q <= !(level || evt || (pulse_q != 16'h0000));
        end
    end

    // ************************************************************
    // adc sequencer
    // ************************************************************

    assign nxt_first = next_enabled(ac_q[7:0], 4'h0);
    assign nxt_after = next_enabled(ac_q[7:0], {1'b0, ch_q} + 4'h1);

    // pass start and end decisions
    always_comb begin
        pass_go = 1'b0;
        pass_end = 1'b0;
        if (!low_power_mode_i) begin
            case (st_q)
                throttle_adc_pkg::ADC_IDLE: pass_go = ac_q[throttle_adc_pkg::AC_START];
                throttle_adc_pkg::ADC_UPDATE_MODE: pass_end = (slot_q == ADC_SLOT_CYC - 1) &&
                    !nxt_after[3];
                throttle_adc_pkg::ADC_WAIT: pass_go = ac_q[throttle_adc_pkg::AC_START] &&
                    (period_q == ADC_PERIOD_CYC - 1);
                default: pass_go = 1'b0;
            endcase
            if (pass_go && !nxt_first[3]) begin
                pass_end = 1'b1;
            end
        end
    end
    assign clear_start = pass_end && !ac_q[throttle_adc_pkg::AC_MODE];

    // state, channel and timers; period counts from the start of a pass
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= throttle_adc_pkg::ADC_IDLE;
            ch_q <= 3'h0;
            slot_q <= 32'h0000_0000;
            period_q <= 32'h0000_0000;
            busy_q <= 1'b0;
            upd_q <= 1'b0;
        end else if (ce_i) begin
            upd_q <= pass_end;
            if (low_power_mode_i) begin
                st_q <= throttle_adc_pkg::ADC_IDLE;
                busy_q <= 1'b0;
            end else if (pass_end) begin
                busy_q <= 1'b0;
                if (ac_q[throttle_adc_pkg::AC_MODE]) begin
                    st_q <= throttle_adc_pkg::ADC_WAIT;
                end else begin
                    st_q <= throttle_adc_pkg::ADC_IDLE;
                end
                if (pass_go) begin
                    period_q <= 32'h0000_0000;
                end else begin
                    period_q <= period_q + 32'h0000_0001;
                end
            end else if (pass_go) begin
                st_q <= throttle_adc_pkg::ADC_UPDATE_MODE;
                ch_q <= nxt_first[2:0];
                slot_q <= 32'h0000_0000;
                period_q <= 32'h0000_0000;
                busy_q <= 1'b1;
            end else begin
                case (st_q)
                    throttle_adc_pkg::ADC_UPDATE_MODE: begin
                        period_q <= period_q + 32'h0000_0001;
                        if (slot_q == ADC_SLOT_CYC - 1) begin
                            slot_q <= 32'h0000_0000;
                            ch_q <= nxt_after[2:0];
                        end else begin
                            slot_q <= slot_q + 32'h0000_0001;
                        end
                    end
                    throttle_adc_pkg::ADC_WAIT: begin
                        period_q <= period_q + 32'h0000_0001;
                        if (!ac_q[throttle_adc_pkg::AC_START]) begin
                            st_q <= throttle_adc_pkg::ADC_IDLE;
                        end
                    end
                    default: st_q <= throttle_adc_pkg::ADC_IDLE;
                endcase
            end
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;
    assign cpu_throttle_n_o = throttle_n_q;
    assign adc_busy_o = busy_q;
    assign adc_ch_sel_o = ch_q;
    assign adc_update_o = upd_q;
    assign adc_range_select_o = ac_q[throttle_adc_pkg::AC_RANGE];

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_read_cfg;
        (ce_i && reg_rd_i && reg_cmd_i == throttle_adc_pkg::CMD_THROTTLE_CFG)
            |=> (reg_rvalid_o && reg_rdata_o == $past(tc_q));
    endproperty
    a_read_cfg: assert property (p_read_cfg) else $error("bad config read");
    property p_dchg_cause;
        deg_hit[0] |-> (battery_discharge_current_i > dchg_thr);
    endproperty
    a_dchg_cause: assert property (p_dchg_cause) else $error("trip below level");
    property p_dchg_gap;
        (ce_i && !deg_raw[0]) |=> !deg_hit[0];
    endproperty
    a_dchg_gap: assert property (p_dchg_gap) else $error("trip without filter");
    property p_droop;
        (ce_i && tc_q[7] && input_droop_i) |=> !cpu_throttle_n_o;
    endproperty
    a_droop: assert property (p_droop) else $error("droop not throttled");
    property p_vap_set;
        (ce_i && vap_rise) |=> tc_q[2];
    endproperty
    a_vap_set: assert property (p_vap_set) else $error("protect did not set bit");
    property p_bat_pulse;
        (ce_i && tc_q[1] && bat_prev_q && !battery_present_i) |=> !cpu_throttle_n_o;
    endproperty
    a_bat_pulse: assert property (p_bat_pulse) else $error("no removal pulse");
    property p_ac_pulse;
        (ce_i && tc_q[0] && ac_prev_q && !adapter_present_i) |=> !cpu_throttle_n_o;
    endproperty
    a_ac_pulse: assert property (p_ac_pulse) else $error("no adapter pulse");
    property p_order;
        (adc_busy_o && $past(adc_busy_o)) |-> (adc_ch_sel_o >= $past(adc_ch_sel_o));
    endproperty
    a_order: assert property (p_order) else $error("channel order broken");
    property p_low_power;
        (ce_i && low_power_mode_i) |=> !adc_busy_o;
    endproperty
    a_low_power: assert property (p_low_power) else $error("adc on in low power");
    property p_periodic;
        (ce_i && pass_end && ac_q[15]) |=> (st_q == throttle_adc_pkg::ADC_WAIT && adc_update_o);
    endproperty
    a_periodic: assert property (p_periodic) else $error("no wait after pass");
    property p_start_clear;
        (ce_i && pass_end && !ac_q[15] && !wr_ac) |=> !ac_q[14];
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start not cleared");
    property p_quiet;
        (ce_i && !level && !evt && pulse_q == 16'h0000) |=> cpu_throttle_n_o;
    endproperty
    a_quiet: assert property (p_quiet) else $error("throttle without source");

    c_bat_pulse: cover property (ce_i && evt ##1 !cpu_throttle_n_o);
    c_one_shot: cover property (adc_busy_o ##[1:1000] adc_update_o);
    c_wait: cover property (st_q == throttle_adc_pkg::ADC_WAIT);
    c_dchg_trip: cover property (deg_hit[0] && tc_q[3]);

endmodule

`default_nettype wire

// ==== verif/host_model.sv ====
// host side: register port master of the throttle and adc block
// assumes the bench calls wr and rd from one process at a time
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // clock
    input wire logic sys_clk_i,
    // register port
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_cmd_o,
    output logic [15:0] reg_wdata_o,
    input wire logic [15:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    // *****
    // idle bus at time zero
    // *****
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_cmd_o = 8'h00;
        reg_wdata_o = 16'h0000;
    end
    // one strobe cycle; command inverted on release so stale codes never match
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge sys_clk_i);
        reg_wr_o <= 1'b1;
        reg_cmd_o <= c;
        reg_wdata_o <= d;
        @(posedge sys_clk_i);
        reg_wr_o <= 1'b0;
        reg_cmd_o <= ~c;
        reg_wdata_o <= ~d;
    endtask
    // answer comes on the taking edge, sampled mid-cycle after it
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        @(posedge sys_clk_i);
        reg_rd_o <= 1'b1;
        reg_cmd_o <= c;
        @(posedge sys_clk_i);
        reg_rd_o <= 1'b0;
        reg_cmd_o <= ~c;
        @(negedge sys_clk_i);
        d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 16'hdead;
    endtask
endmodule
`default_nettype wire

// ==== verif/throttle_and_adc_config_tb_top.sv ====
// self-checking bench for the throttle and adc register block
// assumes shortened deglitch and adc counts given at the instance
`timescale 1ns/100ps
`default_nettype none
module throttle_and_adc_config_tb_top;
    // *****
    // clock, stimulus, instances
    // *****
    logic sys_clk = 1'b0, rstn = 1'b0, wr, rd, rv, thr_n, busy, upd, rng;
    logic drp = 0, cmp = 0, crit = 0, bat = 1, acp = 1, min_voltage_protect_mode = 0, lpm = 0;
    logic [7:0] cmd;
    logic [15:0] wd, rdat, q, dchg = 16'h0000;
    logic [2:0] ch;
    logic ce = 1, nlong = 0, lsv = 0;
    logic [15:0] icur = 16'h0000, ilim = 16'h0064;
    // shortened filter and adc counts so the run stays short
    localparam int unsigned D1 = 8, D6 = 12, D12 = 16, N1 = 6, N50 = 20, SLOT = 4, PER = 60;
    int n_errors = 0, n_tests = 0, cyc = 0, k;
    always #20 sys_clk = ~sys_clk;
    host_model host_model_i (.sys_clk_i(sys_clk), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_cmd_o(cmd), .reg_wdata_o(wd), .reg_rdata_i(rdat), .reg_rvalid_i(rv));
    throttle_adc_config #(.DEG_1P6MS_CYC(D1), .DEG_6MS_CYC(D6), .DEG_12MS_CYC(D12),
        .NOM_1MS_CYC(N1), .NOM_50MS_CYC(N50), .ADC_SLOT_CYC(SLOT), .ADC_PERIOD_CYC(PER))
    throttle_adc_config_i (.sys_clk_i(sys_clk), .rstn_i(rstn), .ce_i(ce),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_cmd_i(cmd), .reg_wdata_i(wd),
        .reg_rdata_o(rdat), .reg_rvalid_o(rv), .battery_discharge_current_i(dchg),
        .input_current_i(icur), .host_input_current_limit_i(ilim),
        .nominal_deglitch_long_i(nlong), .input_droop_i(drp), .ext_comparator_i(cmp),
        .critical_input_overcurrent_i(crit), .low_system_voltage_i(lsv),
        .battery_present_i(bat), .adapter_present_i(acp), .min_voltage_protect_mode_i(min_voltage_protect_mode),
        .low_power_mode_i(lpm), .cpu_throttle_n_o(thr_n), .adc_busy_o(busy),
        .adc_ch_sel_o(ch), .adc_update_o(upd), .adc_range_select_o(rng));
    // compare and count; the seen value is four-state on purpose
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic nw(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic end_sim;
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // hang guard: the whole run needs well under this many cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic t_levels;
        host_model_i.rd(8'h34, q); chk(q, 16'h81a0);
        host_model_i.rd(8'h35, q); chk(q, 16'h2000);
        host_model_i.rd(8'h36, q); chk(q, 16'h0000);
        chk(rng, 1'b1);
        @(posedge sys_clk) drp <= 1; nw(2); chk(thr_n, 1'b0);
        @(posedge sys_clk) drp <= 0; nw(2); chk(thr_n, 1'b1);
        @(posedge sys_clk) crit <= 1; nw(2); chk(thr_n, 1'b0);
        @(posedge sys_clk) crit <= 0; cmp <= 1; nw(3); chk(thr_n, 1'b1);
        host_model_i.wr(8'h34, 16'h8160); nw(2); chk(thr_n, 1'b0);
        @(posedge sys_clk) cmp <= 0; drp <= 1; nw(3); chk(thr_n, 1'b1);
        @(posedge sys_clk) drp <= 0;
        $display("level sources done");
    endtask
    task automatic t_pulses;
        host_model_i.wr(8'h34, 16'h0003);
        @(posedge sys_clk) bat <= 0;
        k = 0; repeat (300) begin nw(1); k += !thr_n; end
        chk(k, 250);
        @(posedge sys_clk) acp <= 0;
        k = 0; repeat (300) begin nw(1); k += !thr_n; end
        chk(k, 250);
        @(posedge sys_clk) min_voltage_protect_mode <= 1; nw(2);
        host_model_i.rd(8'h34, q); chk(q, 16'h0007);
        $display("one-shot sources done");
    endtask
    // code 0 means 128 mA, code 1 means 512 mA; 00 deglitch is 8 cycles here
    task automatic t_dchg(input logic [15:0] cfg, input logic [15:0] lim);
        host_model_i.wr(8'h34, cfg);
        @(posedge sys_clk) dchg <= lim; nw(20); chk(thr_n, 1'b1);
        @(posedge sys_clk) dchg <= lim + 16'h0001; nw(5); chk(thr_n, 1'b1);
        nw(6); chk(thr_n, 1'b0);
        @(posedge sys_clk) dchg <= 16'h0000; nw(2); chk(thr_n, 1'b1);
        $display("discharge trip done");
    endtask
    task automatic t_adc;
        host_model_i.wr(8'h35, 16'h4005);
        for (k = 0; k < 20 && busy !== 1'b1; k++) nw(1);
        chk(ch, 3'h0); nw(4); chk(ch, 3'h2);
        for (k = 0; k < 20 && upd !== 1'b1; k++) nw(1);
        chk(upd, 1'b1); chk(rng, 1'b0);
        host_model_i.rd(8'h35, q); chk(q, 16'h0005);
        host_model_i.wr(8'h35, 16'h4080);
        nw(2); chk(busy, 1'b1); chk(ch, 3'h7);
        @(posedge sys_clk) lpm <= 1; nw(2); chk(busy, 1'b0);
        host_model_i.rd(8'h35, q); chk(q, 16'h4080);
        @(posedge sys_clk) lpm <= 0;
        $display("adc sequencing done");
    endtask
    // nominal filter, low-voltage pulse, clock-enable freeze, periodic adc
    task automatic t_misc;
        host_model_i.wr(8'h34, 16'h0010);
        @(posedge sys_clk) icur <= 16'h006e; nw(12); chk(thr_n, 1'b1);
        @(posedge sys_clk) icur <= 16'h006f; nw(4); chk(thr_n, 1'b1);
        nw(6); chk(thr_n, 1'b0);
        @(posedge sys_clk) icur <= 16'h0000; nlong <= 1; nw(2); chk(thr_n, 1'b1);
        @(posedge sys_clk) icur <= 16'h006f; nw(12); chk(thr_n, 1'b1);
        nw(12); chk(thr_n, 1'b0);
        @(posedge sys_clk) icur <= 16'h0000; nlong <= 0;
        host_model_i.wr(8'h34, 16'h0004);
        @(posedge sys_clk) lsv <= 1;
        k = 0; repeat (300) begin nw(1); k += !thr_n; end
        chk(k, 250);
        @(posedge sys_clk) ce <= 0;
        host_model_i.wr(8'h34, 16'h0000);
        @(posedge sys_clk) ce <= 1; lsv <= 0;
        host_model_i.rd(8'h34, q); chk(q, 16'h0004);
        host_model_i.wr(8'h35, 16'hc001);
        k = 0; repeat (130) begin nw(1); k += upd; end
        chk(k, 3);
        host_model_i.rd(8'h35, q); chk(q, 16'hc001);
        host_model_i.wr(8'h35, 16'h8001); nw(70); chk(busy, 1'b0);
        $display("misc sources and periodic adc done");
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        t_levels();
        t_pulses();
        t_dchg(16'h0008, 16'h0080);
        t_dchg(16'h0408, 16'h0200);
        t_adc();
        t_misc();
        end_sim();
    end
endmodule
`default_nettype wire
